// >>> hdl/loc_framer_pkg.sv
// Constants and types shared by the location packet framer files.
// Assumes a 100 MHz core clock and a byte-wide packet stream.
package loc_framer_pkg;
    // ------------------------------------------------------------
    // Packet layout
    // ------------------------------------------------------------
    localparam logic [7:0]  PKT_TYPE    = 8'h47;
    localparam logic [15:0] CODE_REL    = 16'h0011;
    localparam logic [15:0] CODE_SYNC   = 16'h0081;
    localparam logic [7:0]  FIELD_SPEED = 8'h01;
    localparam logic [5:0]  HDR_LEN     = 6'h05;
    localparam logic [5:0]  TS_REL_LEN  = 6'h04;
    localparam logic [5:0]  TS_SYNC_LEN = 6'h08;
    localparam logic [5:0]  BODY_LEN    = 6'h12;
    localparam logic [5:0]  SPEED_LEN   = 6'h07;
    localparam logic [5:0]  TRAIL_LEN   = 6'h02;
    // Body offsets, counted from the first byte after the timestamp.
    localparam logic [5:0]  OFS_FLAGS   = 6'h0c;
    localparam logic [5:0]  OFS_ORIENT  = 6'h0e;
    localparam logic [5:0]  OFS_OPT     = 6'h12;
    localparam int          ORIENT_W    = 12;

    // ------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_BEACON   = 8'h04;
    localparam logic [7:0] REG_POS_X    = 8'h08;
    localparam logic [7:0] REG_POS_Y    = 8'h0c;
    localparam logic [7:0] REG_POS_Z    = 8'h10;
    localparam logic [7:0] REG_FLAGS    = 8'h14;
    localparam logic [7:0] REG_ORIENT   = 8'h18;
    localparam logic [7:0] REG_SPEED_XY = 8'h1c;
    localparam logic [7:0] REG_SPEED_Z  = 8'h20;
    localparam logic [7:0] REG_SYNC_LO  = 8'h24;
    localparam logic [7:0] REG_SYNC_HI  = 8'h28;
    localparam logic [7:0] REG_STATUS   = 8'h2c;
    localparam logic [7:0] REG_UPTIME   = 8'h30;
    localparam int CTRL_START = 0;
    localparam int CTRL_SYNC  = 1;
    localparam int CTRL_SPEED = 2;
    localparam int CTRL_UNITS = 3;
    localparam int RF_UNAVAIL = 0;
    localparam int RF_OUTSIDE = 1;
    localparam int RF_PAIR    = 2;
    localparam logic       UNITS_MS_RESET = 1'b1;
    localparam logic [1:0] RESP_OKAY      = 2'b00;
    localparam logic [1:0] RESP_SLVERR    = 2'b10;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_MS_NS    = 1000000;
    localparam int TICK_64TH_NS  = 15625000;
    localparam int MS_CYCLES     = TICK_MS_NS / CLK_PERIOD_NS;
    localparam int S64_CYCLES    = TICK_64TH_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic        sync;
        logic        speed_en;
        logic        units_ms;
        logic [7:0]  beacon;
        logic [31:0] x, y, z;
        logic        unavail, outside, pair;
        logic [11:0] orient;
        logic [15:0] sx, sy, sz;
        logic [63:0] sync_ts;
    } regs_t;
    typedef struct packed {
        regs_t       cfg;
        logic [31:0] up;
    } frame_t;
    typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_SEND = 2'b10} frame_state_t;
    typedef struct packed {
        logic         aw_got, w_got, bvalid, rvalid;
        logic [7:0]   aw_addr;
        logic [31:0]  w_data, rdata;
        logic [3:0]   w_strb;
        logic [1:0]   bresp, rresp;
        regs_t        regs;
        frame_state_t fsm;
        frame_t       frame;
        logic [5:0]   idx;
        logic         tx_valid, tx_last;
        logic [7:0]   tx_data;
        logic [15:0]  pkt_count;
    } framer_state_t;
    typedef struct packed {
        logic [23:0] div;
        logic [31:0] count;
    } timer_state_t;
endpackage

// >>> hdl/uptime_timer.sv
// Free-running uptime counter used as the start-relative timestamp.
// Assumes one core clock; tick lengths come from the top parameters.
`timescale 1ns/1ps
`default_nettype none
module uptime_timer
    import loc_framer_pkg::*;
#(
    parameter int unsigned MS_CYC  = MS_CYCLES,
    parameter int unsigned S64_CYC = S64_CYCLES
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // Unit select and count
    input  wire logic        units_ms,
    output logic [31:0]      count
);
    timer_state_t s_q;
    timer_state_t n;
    logic [23:0]  limit;

    if (MS_CYC < 2 || S64_CYC < 2 || S64_CYC > 24'hffffff || MS_CYC > 24'hffffff) begin : g_chk
        $error("uptime_timer: tick length out of range");
    end

    // The divider uses >= so a unit switch never strands it above the limit.
    always_comb begin
        n     = s_q;
        limit = units_ms ? 24'(MS_CYC - 1) : 24'(S64_CYC - 1);
        if (s_q.div >= limit) begin
            n.div   = 24'h000000;
            n.count = s_q.count + 32'h00000001;
        end else begin
            n.div = s_q.div + 24'h000001;
        end
    end

    // State register.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= n;
        end
    end

    assign count = s_q.count;
endmodule
`default_nettype wire

// >>> hdl/packet_byte_mux.sv
// Selects one byte of a location packet from a frame snapshot.
// Purely combinational; the caller registers the byte.
`timescale 1ns/1ps
`default_nettype none
module packet_byte_mux
    import loc_framer_pkg::*;
(
    // Frame snapshot and byte index
    input  wire frame_t     frame,
    input  wire logic [5:0] idx,
    // Selected byte and lengths
    output logic [7:0]      byte_out,
    output logic [7:0]      data_len,
    output logic [5:0]      total_len
);
    logic [5:0]  ts_len, opt_len, rel, ts_i, opt_k;
    logic [63:0] ts;
    logic [31:0] coord;
    logic [47:0] speed;
    logic [15:0] code, orient_w;

    // Field values are sent least significant byte first.
    always_comb begin
        ts_len    = frame.cfg.sync ? TS_SYNC_LEN : TS_REL_LEN;
        opt_len   = frame.cfg.speed_en ? SPEED_LEN : 6'h00;
        data_len  = {2'b00, ts_len + BODY_LEN + opt_len};
        total_len = HDR_LEN + ts_len + BODY_LEN + opt_len + TRAIL_LEN;
        code      = frame.cfg.sync ? CODE_SYNC : CODE_REL;
        ts        = frame.cfg.sync ? frame.cfg.sync_ts : {32'h00000000, frame.up};
        ts_i      = idx - HDR_LEN;
        rel       = idx - HDR_LEN - ts_len;
        opt_k     = rel - OFS_OPT - 6'h01;
        speed     = {frame.cfg.sz, frame.cfg.sy, frame.cfg.sx};
        orient_w  = {3'b000, frame.cfg.pair, frame.cfg.orient};
        case (rel[3:2])
            2'b00:   coord = frame.cfg.x;
            2'b01:   coord = frame.cfg.y;
            default: coord = frame.cfg.z;
        endcase
        byte_out = 8'h00;
        if (idx == 6'h00) begin
            byte_out = frame.cfg.beacon;
        end else if (idx == 6'h01) begin
            byte_out = PKT_TYPE;
        end else if (idx == 6'h02) begin
            byte_out = code[7:0];
        end else if (idx == 6'h03) begin
            byte_out = code[15:8];
        end else if (idx == 6'h04) begin
            byte_out = data_len;
        end else if (idx < HDR_LEN + ts_len) begin
            byte_out = ts[{ts_i[2:0], 3'b000} +: 8];
        end else if (rel < OFS_FLAGS) begin
            byte_out = coord[{rel[1:0], 3'b000} +: 8];
        end else if (rel == OFS_FLAGS) begin
            byte_out = {frame.cfg.outside, 5'b00000, frame.cfg.units_ms, frame.cfg.unavail};
        end else if (rel == OFS_ORIENT) begin
            byte_out = orient_w[7:0];
        end else if (rel == OFS_ORIENT + 6'h01) begin
            byte_out = orient_w[15:8];
        end else if (frame.cfg.speed_en && rel == OFS_OPT) begin
            byte_out = FIELD_SPEED;
        end else if (frame.cfg.speed_en && rel > OFS_OPT && rel < OFS_OPT + SPEED_LEN) begin
            byte_out = speed[{opt_k[2:0], 3'b000} +: 8];
        end
    end
endmodule
`default_nettype wire

// >>> hdl/location_packet_framer.sv
// Location packet framer: AXI4-Lite registers and a byte stream out.
// Assumes the stream sink honours valid/ready and the bus is AXI4-Lite.
//
// Summary of operation
// - Byte 0 beacon address, byte 1 0x47.
// - Relative variant: code 0x0011, then length N.
// - Relative variant: 32-bit uptime timestamp at 5.
// - Relative variant: X, Y, Z at 9/13/17.
// - Flags at 21: bit0 unavailable, 2..6 zero.
// - Flags bit 7 set outside geofence.
// - Flags bit 1 marks millisecond timestamp units.
// - Zero byte 22, orientation word at 23.
// - Orientation bit 12 pair centre; 13..15 zero.
// - Optional bytes from 27, then two zeros.
// - Speed field: code 1, three int16 speeds.
// - Synchronized variant: code 0x0081, 64-bit time.
// - Synchronized variant: X, Y, Z at 13/17/21.
// - Synchronized: flags 25, zero 26, orientation 27.
// - Synchronized: optional bytes from 31, two zeros.
`timescale 1ns/1ps
`default_nettype none
module location_packet_framer
    import loc_framer_pkg::*;
#(
    parameter int unsigned MS_CYC  = MS_CYCLES,
    parameter int unsigned S64_CYC = S64_CYCLES
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // AXI4-Lite write address and data
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Packet byte stream
    output logic [7:0]       tx_data,
    output logic             tx_valid,
    output logic             tx_last,
    input  wire logic        tx_ready
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Merges write data into an old word under the byte strobes.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Word seen at a register address; unmapped addresses give zero.
    function automatic logic [31:0] reg_word(input regs_t r, input logic [7:0] a,
                                             input logic [31:0] status, input logic [31:0] up);
        logic [31:0] w;
        w = 32'h00000000;
        case (a)
            REG_CTRL:     w = {28'h0000000, r.units_ms, r.speed_en, r.sync, 1'b0};
            REG_BEACON:   w = {24'h000000, r.beacon};
            REG_POS_X:    w = r.x;
            REG_POS_Y:    w = r.y;
            REG_POS_Z:    w = r.z;
            REG_FLAGS:    w = {29'h00000000, r.pair, r.outside, r.unavail};
            REG_ORIENT:   w = {20'h00000, r.orient};
            REG_SPEED_XY: w = {r.sy, r.sx};
            REG_SPEED_Z:  w = {16'h0000, r.sz};
            REG_SYNC_LO:  w = r.sync_ts[31:0];
            REG_SYNC_HI:  w = r.sync_ts[63:32];
            REG_STATUS:   w = status;
            REG_UPTIME:   w = up;
            default:      w = 32'h00000000;
        endcase
        return w;
    endfunction

    // True for every address that the map decodes.
    function automatic logic mapped(input logic [7:0] a);
        return (a[1:0] == 2'b00) && (a <= REG_UPTIME);
    endfunction

    // ------------------------------------------------------------
    // State and submodules
    // ------------------------------------------------------------
    framer_state_t s_q;
    framer_state_t n;
    logic [31:0]   uptime;
    logic [7:0]    mux_byte;
    logic [7:0]    mux_data_len;
    logic [5:0]    mux_total;
    logic          busy;
    logic          start;
    logic [31:0]   status_w;
    logic [31:0]   wv;

    uptime_timer #(
        .MS_CYC  (MS_CYC),
        .S64_CYC (S64_CYC)
    ) u_timer (
        .core_clk (core_clk),
        .reset    (reset),
        .units_ms (s_q.regs.units_ms),
        .count    (uptime)
    );

    packet_byte_mux u_mux (
        .frame     (s_q.frame),
        .idx       (s_q.idx),
        .byte_out  (mux_byte),
        .data_len  (mux_data_len),
        .total_len (mux_total)
    );

    // Handshake readies are combinational from the state.
    assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
    assign s_axi_wready  = !s_q.w_got && !s_q.bvalid;
    assign s_axi_arready = !s_q.rvalid;
    assign busy          = (s_q.fsm == ST_SEND) || s_q.tx_valid;
    assign status_w      = {s_q.pkt_count, 15'h0000, busy};

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------

    // Bus slave, register writes and the packet sequencer in one pass.
    // A start while busy is dropped: a half-sent packet must not change.
    always_comb begin
        n     = s_q;
        start = 1'b0;
        wv    = 32'h00000000;
        if (s_q.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (s_axi_awvalid && s_axi_awready) begin
            n.aw_got  = 1'b1;
            n.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            n.w_got  = 1'b1;
            n.w_data = s_axi_wdata;
            n.w_strb = s_axi_wstrb;
        end
        if (n.aw_got && n.w_got && !s_q.bvalid) begin
            n.aw_got = 1'b0;
            n.w_got  = 1'b0;
            n.bvalid = 1'b1;
            n.bresp  = mapped(n.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            wv = merge(reg_word(s_q.regs, n.aw_addr, status_w, uptime), n.w_data, n.w_strb);
            case (n.aw_addr)
                REG_CTRL: begin
                    n.regs.sync     = wv[CTRL_SYNC];
                    n.regs.speed_en = wv[CTRL_SPEED];
                    n.regs.units_ms = wv[CTRL_UNITS];
                    start           = n.w_strb[0] && n.w_data[CTRL_START];
                end
                REG_BEACON:   n.regs.beacon = wv[7:0];
                REG_POS_X:    n.regs.x = wv;
                REG_POS_Y:    n.regs.y = wv;
                REG_POS_Z:    n.regs.z = wv;
                REG_FLAGS: begin
                    n.regs.unavail = wv[RF_UNAVAIL];
                    n.regs.outside = wv[RF_OUTSIDE];
                    n.regs.pair    = wv[RF_PAIR];
                end
                REG_ORIENT:   n.regs.orient = wv[ORIENT_W-1:0];
                REG_SPEED_XY: begin
                    n.regs.sx = wv[15:0];
                    n.regs.sy = wv[31:16];
                end
                REG_SPEED_Z:  n.regs.sz = wv[15:0];
                REG_SYNC_LO:  n.regs.sync_ts[31:0] = wv;
                REG_SYNC_HI:  n.regs.sync_ts[63:32] = wv;
                default:      n.regs = s_q.regs;
            endcase
        end
        if (s_q.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            n.rvalid = 1'b1;
            n.rdata  = reg_word(s_q.regs, s_axi_araddr, status_w, uptime);
            n.rresp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        if (s_q.tx_valid && tx_ready) begin
            n.tx_valid = 1'b0;
        end
        case (s_q.fsm)
            ST_IDLE: begin
                if (start && !busy) begin
                    n.frame.cfg = n.regs;
                    n.frame.up  = uptime;
                    n.idx       = 6'h00;
                    n.fsm       = ST_SEND;
                end
            end
            ST_SEND: begin
                if (!n.tx_valid) begin
                    n.tx_valid = 1'b1;
                    n.tx_data  = mux_byte;
                    n.tx_last  = (s_q.idx == mux_total - 6'h01);
                    n.idx      = s_q.idx + 6'h01;
                    if (n.tx_last) begin
                        n.fsm       = ST_IDLE;
                        n.pkt_count = s_q.pkt_count + 16'h0001;
                    end
                end
            end
            default: n.fsm = ST_IDLE;
        endcase
    end

    // State register; control state starts idle with millisecond units.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s_q               <= '0;
            s_q.fsm           <= ST_IDLE;
            s_q.regs.units_ms <= UNITS_MS_RESET;
        end else begin
            s_q <= n;
        end
    end

    // Outputs come straight from the state register.
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp  = s_q.bresp;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata  = s_q.rdata;
    assign s_axi_rresp  = s_q.rresp;
    assign tx_valid     = s_q.tx_valid;
    assign tx_data      = s_q.tx_data;
    assign tx_last      = s_q.tx_last;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic [5:0] cur_pos;
    logic [5:0] flag_pos;
    logic [5:0] opt_pos;
    assign cur_pos  = s_q.idx - 6'h01;
    assign flag_pos = HDR_LEN + (s_q.frame.cfg.sync ? TS_SYNC_LEN : TS_REL_LEN) + OFS_FLAGS;
    assign opt_pos  = flag_pos + OFS_OPT - OFS_FLAGS;

    a_hdr_addr: assert property (@(posedge core_clk) disable iff (reset)
        tx_valid && cur_pos == 6'h00 |-> tx_data == s_q.frame.cfg.beacon)
        else $error("first byte is not the beacon address");
    a_hdr_type: assert property (@(posedge core_clk) disable iff (reset)
        tx_valid && cur_pos == 6'h01 |-> tx_data == PKT_TYPE)
        else $error("second byte is not the packet type");
    a_code_low: assert property (@(posedge core_clk) disable iff (reset)
        tx_valid && cur_pos == 6'h02
        |-> tx_data == (s_q.frame.cfg.sync ? CODE_SYNC[7:0] : CODE_REL[7:0]))
        else $error("data code low byte wrong");
    a_len_field: assert property (@(posedge core_clk) disable iff (reset)
        tx_valid && cur_pos == 6'h04 |-> tx_data == mux_data_len
        && tx_data == (s_q.frame.cfg.sync ? 8'h1a : 8'h16) + (s_q.frame.cfg.speed_en ? 8'h07 : 8'h00))
        else $error("payload length byte wrong");
    a_flag_bits: assert property (@(posedge core_clk) disable iff (reset)
        tx_valid && cur_pos == flag_pos |-> tx_data[6:2] == 5'h00
        && tx_data[0] == s_q.frame.cfg.unavail && tx_data[7] == s_q.frame.cfg.outside
        && tx_data[1] == s_q.frame.cfg.units_ms)
        else $error("flags byte wrong");
    a_orient_high: assert property (@(posedge core_clk) disable iff (reset)
        tx_valid && cur_pos == flag_pos + 6'h03
        |-> tx_data == {3'b000, s_q.frame.cfg.pair, s_q.frame.cfg.orient[11:8]})
        else $error("orientation high byte wrong");
    a_speed_code: assert property (@(posedge core_clk) disable iff (reset)
        tx_valid && s_q.frame.cfg.speed_en && cur_pos == opt_pos |-> tx_data == FIELD_SPEED)
        else $error("speed field code wrong");
    a_trail_zero: assert property (@(posedge core_clk) disable iff (reset)
        tx_valid && tx_last |-> tx_data == 8'h00 && cur_pos == mux_total - 6'h01
        && $past(tx_data) == 8'h00)
        else $error("last byte not a trailing zero");
    a_stall_hold: assert property (@(posedge core_clk) disable iff (reset)
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
        else $error("stream byte changed while stalled");
    a_write_resp: assert property (@(posedge core_clk) disable iff (reset)
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> s_axi_bvalid ##0 !s_axi_awready [*1])
        else $error("write response missing");
endmodule
`default_nettype wire

// >>> sim/loc_sink.sv
// Network host model: takes packet bytes and stalls at random.
// Assumes the bench seeds the random generator once.
`timescale 1ns/1ps
`default_nettype none
module loc_sink
    import loc_framer_pkg::*;
(
    // Clock and byte stream
    input  wire logic       core_clk,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    input  wire logic       tx_last,
    output logic            tx_ready
);
    logic [7:0] got[$];
    int         pkts = 0;
    int         fixes = 0;
    initial tx_ready = 1'b0;
    // Log bytes in wire order; random stalls prove each byte holds.
    // Taken at the falling edge, where the byte and its flags have settled.
    // wire byte order
    always @(negedge core_clk) begin
        if (tx_valid && tx_ready) begin
            got.push_back(tx_data);
            if (tx_last) begin
                pkts <= pkts + 1;
                // A fix counts only with valid coordinates.
                if (!got[(got[2] == CODE_SYNC[7:0]) ? 25 : 21][0]) fixes <= fixes + 1;
            end
        end
    end
    // Ready changes right after the rising edge.
    always @(posedge core_clk) begin
        tx_ready <= ($urandom % 3) != 0;
    end
endmodule
`default_nettype wire

// >>> sim/location_packet_framer_tb.sv
// Bench for the location packet framer: random packets set up over
// the register bus, bytes checked at the sink model.
`timescale 1ns/1ps
`default_nettype none
module location_packet_framer_tb
    import loc_framer_pkg::*;
;
    logic         core_clk = 1'b0;
    logic         reset = 1'b1;
    logic [7:0]   awaddr = 8'h00, araddr = 8'h00, txd;
    logic [31:0]  wdata = 32'h0, rdata, wd[11];
    logic         awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic         awready, wready, bvalid, arready, rvalid, txv, txl, txr;
    logic [1:0]   bresp, rresp;
    logic [255:0] rnd;
    logic [7:0]   exp_q[$];
    int           failures = 0, checks_done = 0, fixes_exp = 0;
    logic [31:0]  lo, hi, ts;
    logic [1:0]   rr;
    regs_t        c;
    always #5 core_clk = ~core_clk;
    // Short tick counts keep the timer moving within the run.
    location_packet_framer #(.MS_CYC(4), .S64_CYC(8)) dut_u (
        .core_clk(core_clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .tx_data(txd), .tx_valid(txv), .tx_last(txl), .tx_ready(txr));
    loc_sink sink_u (.core_clk(core_clk), .tx_data(txd), .tx_valid(txv), .tx_last(txl),
        .tx_ready(txr));
    task automatic close_out();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk_bus(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("wrong value t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        chk_bus({24'h0, g}, {24'h0, e});
    endtask
    // Handshakes are judged before the edge, so ready seen at the
    // edge is the value that the slave really offered.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w, b;
        logic [1:0] r;
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid} <= 2'b11;
        for (int n = 0; n < 99; n++) begin
            @(negedge core_clk);
            {aw, w, b, r} = {awvalid & awready, wvalid & wready, bvalid, bresp};
            @(posedge core_clk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (b) begin
                chk_bus({30'h0, r}, {30'h0, er});
                return;
            end
        end
        failures++;
        close_out();
    endtask
    task automatic rd_raw(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        logic ar, rv;
        araddr <= a;
        arvalid <= 1'b1;
        for (int n = 0; n < 99; n++) begin
            @(negedge core_clk);
            {ar, rv, v, r} = {arvalid & arready, rvalid, rdata, rresp};
            @(posedge core_clk);
            if (ar) arvalid <= 1'b0;
            if (rv) return;
        end
        failures++;
        close_out();
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic [31:0] v;
        logic [1:0]  r;
        rd_raw(a, v, r);
        chk_bus(v, ed);
        chk_bus({30'h0, r}, {30'h0, er});
    endtask
    function automatic void put(input logic [95:0] v, input int n);
        for (int k = 0; k < n; k++) exp_q.push_back(v[8*k +: 8]);
    endfunction
    // Expected packet, every field least significant byte first.
    // header and body
    function automatic void build(input regs_t r);
        exp_q = {r.beacon, PKT_TYPE};
        put(r.sync ? CODE_SYNC : CODE_REL, 2);
        put((r.sync ? 8'h1a : 8'h16) + (r.speed_en ? 8'h07 : 8'h00), 1);
        put(r.sync_ts, r.sync ? 8 : 4);
        put({r.z, r.y, r.x}, 12);
        put({r.outside, 5'h0, r.units_ms, r.unavail}, 1);
        put({19'h0, r.pair, r.orient, 8'h0}, 5);
        if (r.speed_en) put({r.sz, r.sy, r.sx, FIELD_SPEED}, 7);
        put(0, 2);
    endfunction
    initial begin
        void'($urandom(61854));
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        rd(REG_CTRL, 32'h8, RESP_OKAY);  // units default
        rd(8'h34, 32'h0, RESP_SLVERR);
        wr(8'h34, 32'h1, RESP_SLVERR);
        // Each variant with and without speed; a second start while busy is dropped.
        for (int i = 0; i < 8; i++) begin
            rnd = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
            c = rnd[233:0];
            {c.speed_en, c.sync} = i[1:0];
            if (i == 2) {c.x, c.orient} = {32'h80000000, 12'he10};
            wd = '{{24'h0, c.beacon}, c.x, c.y, c.z, {29'h0, c.pair, c.outside, c.unavail},
                {rnd[255:236], c.orient}, {c.sy, c.sx}, {16'h0, c.sz}, c.sync_ts[31:0],
                c.sync_ts[63:32], {28'h0, c.units_ms, c.speed_en, c.sync, 1'b1}};
            rd_raw(REG_UPTIME, lo, rr);
            foreach (wd[k]) wr(k == 10 ? REG_CTRL : 8'(4 * k + 4), wd[k], RESP_OKAY);
            wr(REG_CTRL, wd[10], RESP_OKAY);
            rd_raw(REG_UPTIME, hi, rr);
            build(c);
            if (!c.unavail) fixes_exp++;
            for (int n = 0; sink_u.pkts <= i; n++) begin
                @(posedge core_clk);
                if (n > 2000) begin
                    failures++;
                    close_out();
                end
            end
            chk_bus(sink_u.got.size(), exp_q.size());  // length
            ts = {sink_u.got[8], sink_u.got[7], sink_u.got[6], sink_u.got[5]};
            if (!c.sync) chk_bus({31'h0, ts >= lo && ts <= hi}, 32'h1);  // uptime window
            chk_bus(sink_u.fixes, fixes_exp);  // usable fixes
            foreach (exp_q[k]) if (c.sync || k < 5 || k > 8) chk_byte(sink_u.got[k], exp_q[k]);  // bytes
            sink_u.got.delete();
        end
        rd(REG_STATUS, 32'h00080000, RESP_OKAY);
        close_out();
    end
endmodule
`default_nettype wire
